// *** core/fms_supervisor.sv ***
`timescale 1ns/1ps
module fms_supervisor
  import fms_pkg::*;
#(
  parameter logic [FMS_DGL_W-1:0]  IN_DGL_CYC   = FMS_DGL_W'(FMS_IN_DGL_CYC),
  parameter logic [FMS_WDOG_W-1:0] WDOG_S_CYC   = FMS_WDOG_W'(FMS_WDOG_S_CYC),
  parameter logic [FMS_WDOG_W-1:0] WDOG_L_CYC   = FMS_WDOG_W'(FMS_WDOG_L_CYC),
  parameter logic [FMS_MON_W-1:0]  CLK_LOW_CYC  = FMS_MON_W'(FMS_CLK_LOW_CYC)
) (
  input  wire logic                SYS_CLK,
  input  wire logic                NRST,
  input  wire fms_pins_t           PIN_IN,
  input  wire fms_frame_t          FRAME,
  input  wire logic                WATCHDOG_PERIOD_SELECT,
  input  wire logic                AWAKE,
  input  wire logic                MAIN_SUPPLY_OK,
  input  wire logic                LOGIC_SUPPLY_OK,
  input  wire logic                GROUND_OK,
  input  wire logic [FMS_NOUT-1:0] PWM_CHANNEL,
  input  wire logic [FMS_NOUT-1:0] CHANNEL_CONTROL_SIGNAL,
  input  wire logic                EXT_SWITCH_SETTING,
  input  wire logic [FMS_NFLT-1:0] FAULT_COND,
  output logic [FMS_NOUT-1:0]      POWER_CHANNEL_OUTPUTS,
  output logic                     EXTERNAL_SWITCH_CONTROL_OUTPUT,
  output logic                     CLOCK_PIN_O,
  output logic                     CLOCK_PIN_OE,
  output logic                     FAIL_MODE,
  output logic                     LINK_FAILURE_FLAG,
  output logic                     FAIL_FORCE_LEVEL,
  output logic                     CLOCK_VALID,
  output logic [FMS_NFLT-1:0]      FAULT_FLAGS,
  output logic                     REGS_CLEAR
);
  fms_state_t            q;
  fms_state_t            d;
  logic [FMS_NDGL-1:0]   dgl_raw;
  logic                  clk_bad;
  logic                  clk_valid;
  logic [FMS_NFLT-1:0]   fcond;
  logic                  qread;
  logic [FMS_WDOG_W-1:0] wdog_lim;
  logic                  wdog_exp;
  logic                  frame_ok;
  logic                  comm_set;
  logic                  fail_cond;
  logic                  off_cond;
  logic                  fail_exit;
  logic [FMS_NOUT-1:0]   chan_src;
  logic [FMS_NOUT-1:0]   dir_map;

  assign dgl_raw   = {q.s2.direct_drive_inputs, q.s2.fail_force_input};
  assign clk_bad   = q.mon && (q.mon_cnt == CLK_LOW_CYC);
  assign clk_valid = q.mon && q.seen && !clk_bad;
  assign fcond     = (FAULT_COND & ~FMS_FLT_CLK_M) |
                     ({FMS_NFLT{clk_bad}} & FMS_FLT_CLK_M);
  assign qread     = FRAME.done && FRAME.qstat1_read;
  assign wdog_lim  = WATCHDOG_PERIOD_SELECT ? WDOG_L_CYC : WDOG_S_CYC;
  assign wdog_exp  = q.wdog_cnt >= wdog_lim;
  assign frame_ok  = FRAME.done && (FRAME.toggle_bit != q.tog_last) &&
                     (FRAME.bits[FMS_MOD_W-1:0] == '0);
  // a bad frame and a good frame never coincide, so set wins trivially
  assign comm_set  = !frame_ok && ((FRAME.done) || wdog_exp);
  assign fail_cond = q.dgl[0] || q.comm_fail;
  assign off_cond  = !MAIN_SUPPLY_OK && !LOGIC_SUPPLY_OK;
  assign fail_exit = (q.mode == FMS_FAIL) && !fail_cond && !off_cond;
  // without a valid clock the channels take their control signals directly
  assign chan_src  = clk_valid ? PWM_CHANNEL : CHANNEL_CONTROL_SIGNAL;
  assign dir_map   = {1'b0, q.dgl[FMS_NDGL-1:1]};

  always_comb begin
    d    = q;
    d.s1 = PIN_IN;
    d.s2 = q.s1;
    for (int i = 0; i < FMS_NDGL; i++) begin
      if (dgl_raw[i] == q.dgl[i]) begin
        d.dgl_cnt[i] = '0;
      end else if (q.dgl_cnt[i] == IN_DGL_CYC - 1'b1) begin
        d.dgl[i]     = dgl_raw[i];
        d.dgl_cnt[i] = '0;
      end else begin
        d.dgl_cnt[i] = q.dgl_cnt[i] + 1'b1;
      end
    end
    if (q.s2.wake_reset_input) begin
      d.rst_f   = 1'b1;
      d.rst_cnt = '0;
    end else if (q.rst_f) begin
      if (q.rst_cnt == FMS_RST_LIM) begin
        d.rst_f   = 1'b0;
        d.rst_cnt = '0;
      end else begin
        d.rst_cnt = q.rst_cnt + 1'b1;
      end
    end
    if (q.s2.clock_pin == q.clk_f) begin
      d.clk_cnt = '0;
    end else if (q.clk_cnt == FMS_CKD_LIM) begin
      d.clk_f   = q.s2.clock_pin;
      d.clk_cnt = '0;
    end else begin
      d.clk_cnt = q.clk_cnt + 1'b1;
    end
    if (!q.rst_f) begin
      d.mon     = 1'b0;
      d.seen    = 1'b0;
      d.mon_cnt = '0;
    end else if (!q.mon) begin
      d.mon     = 1'b1;
      d.mon_cnt = '0;
    end else if (d.clk_f && !q.clk_f) begin
      d.seen    = 1'b1;
      d.mon_cnt = '0;
    end else if (q.mon_cnt != CLK_LOW_CYC) begin
      d.mon_cnt = q.mon_cnt + 1'b1;
    end
    // flags hold until the cause is gone and quick status 1 is read
    d.faults = (q.faults & ~({FMS_NFLT{qread}} & ~fcond)) |
               fcond;
    if (FRAME.done) begin
      d.tog_last = FRAME.toggle_bit;
    end
    if (frame_ok) begin
      d.wdog_cnt = '0;
    end else if (!wdog_exp) begin
      d.wdog_cnt = q.wdog_cnt + 1'b1;
    end
    d.comm_fail = comm_set ||
                  (q.comm_fail && !(frame_ok && !q.dgl[0]));
    d.link_flag = comm_set || (q.link_flag && !fail_exit);
    case (q.mode)
      FMS_OFF: begin
        if (!off_cond) begin
          d.mode = FMS_NORMAL;
        end
      end
      FMS_NORMAL: begin
        if (off_cond) begin
          d.mode = FMS_OFF;
        end else if (fail_cond) begin
          d.mode = FMS_FAIL;
        end
      end
      FMS_FAIL: begin
        if (off_cond) begin
          d.mode = FMS_OFF;
        end else if (!fail_cond) begin
          d.mode = FMS_NORMAL;
        end
      end
      default: d.mode = FMS_OFF;
    endcase
    if (off_cond) begin
      d.faults    = '0;
      d.comm_fail = 1'b0;
      d.link_flag = 1'b0;
      d.wdog_cnt  = '0;
    end
    if (!GROUND_OK || !MAIN_SUPPLY_OK || q.mode == FMS_OFF) begin
      d.pout = '0;
    end else if (q.mode == FMS_FAIL) begin
      d.pout = dir_map;
    end else begin
      d.pout = chan_src | dir_map;
    end
    if (!GROUND_OK) begin
      d.ext = 1'b1;
    end else if (q.mode != FMS_NORMAL || !AWAKE) begin
      d.ext = 1'b0;
    end else begin
      d.ext = EXT_SWITCH_SETTING;
    end
    // a reset-woken device keeps the pin as an input
    d.clk_oe = AWAKE && !q.rst_f && MAIN_SUPPLY_OK &&
               q.mode != FMS_OFF;
  end

  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      q <= FMS_STATE_RST;
    end else begin
      q <= d;
    end
  end

  assign POWER_CHANNEL_OUTPUTS          = q.pout;
  assign EXTERNAL_SWITCH_CONTROL_OUTPUT = q.ext;
  assign CLOCK_PIN_O                    = 1'b1;
  assign CLOCK_PIN_OE                   = q.clk_oe;
  assign FAIL_MODE                      = q.mode == FMS_FAIL;
  assign LINK_FAILURE_FLAG              = q.link_flag;
  assign FAIL_FORCE_LEVEL               = q.s2.fail_force_input;
  assign CLOCK_VALID                    = clk_valid;
  assign FAULT_FLAGS                    = q.faults;
  assign REGS_CLEAR                     = q.mode == FMS_OFF;

  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!NRST);

  sequence s_fail_exit;
    (q.mode == FMS_FAIL) ##1 (q.mode == FMS_NORMAL);
  endsequence

  property p_clk_report;
    (AWAKE && !q.rst_f && MAIN_SUPPLY_OK && q.mode != FMS_OFF)
      |=> CLOCK_PIN_OE && CLOCK_PIN_O;
  endproperty
  a_clk_report: assert property (p_clk_report)
    else $error("clock pin not driven while awake");

  property p_power_off;
    off_cond |=> FAULT_FLAGS == '0 && !LINK_FAILURE_FLAG;
  endproperty
  a_power_off: assert property (p_power_off)
    else $error("state not cleared at power off");

  property p_main_loss;
    (!MAIN_SUPPLY_OK && GROUND_OK && AWAKE && q.mode == FMS_NORMAL)
      |=> POWER_CHANNEL_OUTPUTS == '0 &&
          EXTERNAL_SWITCH_CONTROL_OUTPUT == $past(EXT_SWITCH_SETTING);
  endproperty
  a_main_loss: assert property (p_main_loss)
    else $error("wrong outputs on main supply loss");

  property p_no_wake_report;
    !MAIN_SUPPLY_OK |=> !CLOCK_PIN_OE;
  endproperty
  a_no_wake_report: assert property (p_no_wake_report)
    else $error("wake reported without main supply");

  property p_gnd_loss;
    !GROUND_OK |=> POWER_CHANNEL_OUTPUTS == '0 &&
                   EXTERNAL_SWITCH_CONTROL_OUTPUT;
  endproperty
  a_gnd_loss: assert property (p_gnd_loss)
    else $error("wrong outputs on ground loss");

  property p_wdog_fail;
    (wdog_exp && !frame_ok) |=> q.comm_fail ##1 q.mode != FMS_NORMAL;
  endproperty
  a_wdog_fail: assert property (p_wdog_fail)
    else $error("watchdog expiry did not force fail mode");

  property p_link_clear;
    s_fail_exit |-> !q.link_flag || $past(comm_set);
  endproperty
  a_link_clear: assert property (p_link_clear)
    else $error("link flag kept after leaving fail mode");

  property p_dgl_time;
    $changed(q.dgl[0]) |-> $past(q.dgl_cnt[0]) == IN_DGL_CYC - 1'b1;
  endproperty
  a_dgl_time: assert property (p_dgl_time)
    else $error("fail-force filter switched early");

  property p_rst_rise;
    (q.s2.wake_reset_input && !q.rst_f) |=> q.rst_f;
  endproperty
  a_rst_rise: assert property (p_rst_rise)
    else $error("wake/reset rising edge delayed");

  property p_clk_latch;
    $fell(q.faults[5]) |-> $past(qread) && !$past(clk_bad) ||
                           $past(off_cond);
  endproperty
  a_clk_latch: assert property (p_clk_latch)
    else $error("clock fail cleared without read");

  property p_fail_drive;
    (q.mode == FMS_FAIL && GROUND_OK && MAIN_SUPPLY_OK)
      |=> POWER_CHANNEL_OUTPUTS == $past(dir_map) &&
          !EXTERNAL_SWITCH_CONTROL_OUTPUT;
  endproperty
  a_fail_drive: assert property (p_fail_drive)
    else $error("fail mode outputs do not follow direct inputs");

  // the switch output must track the setting only while normal, awake and grounded
  property p_ext_normal;
    (q.mode == FMS_NORMAL && GROUND_OK && AWAKE)
      |=> EXTERNAL_SWITCH_CONTROL_OUTPUT == $past(EXT_SWITCH_SETTING);
  endproperty
  a_ext_normal: assert property (p_ext_normal)
    else $error("external switch does not follow its setting");

  property p_pwm_drive;
    (q.mode == FMS_NORMAL && GROUND_OK && MAIN_SUPPLY_OK && clk_valid)
      |=> POWER_CHANNEL_OUTPUTS == ($past(PWM_CHANNEL) | $past(dir_map));
  endproperty
  a_pwm_drive: assert property (p_pwm_drive)
    else $error("normal mode outputs do not follow the pwm unit");
endmodule

// *** core/fms_pkg.sv ***
package fms_pkg;
  localparam int FMS_CLK_HZ      = 40_000_000;
  localparam int FMS_CLK_MHZ     = FMS_CLK_HZ / 1_000_000;
  localparam int FMS_IN_DGL_NS   = 200_000;
  localparam int FMS_RST_DGL_NS  = 10_000;
  localparam int FMS_CLK_DGL_NS  = 2_000;
  localparam int FMS_WDOG_S_MS   = 32;
  localparam int FMS_WDOG_L_MS   = 128;
  localparam int FMS_CLK_LOW_HZ  = 100;
  localparam int FMS_IN_DGL_CYC  = FMS_IN_DGL_NS * FMS_CLK_MHZ / 1000;
  localparam int FMS_RST_DGL_CYC = FMS_RST_DGL_NS * FMS_CLK_MHZ / 1000;
  localparam int FMS_CLK_DGL_CYC = FMS_CLK_DGL_NS * FMS_CLK_MHZ / 1000;
  localparam int FMS_WDOG_S_CYC  = FMS_WDOG_S_MS * FMS_CLK_MHZ * 1000;
  localparam int FMS_WDOG_L_CYC  = FMS_WDOG_L_MS * FMS_CLK_MHZ * 1000;
  localparam int FMS_CLK_LOW_CYC = FMS_CLK_HZ / FMS_CLK_LOW_HZ;
  localparam int FMS_NDIR = 4;
  localparam int FMS_NDGL = FMS_NDIR + 1;
  localparam int FMS_NOUT = 5;
  localparam int FMS_NFLT = 8;
  localparam int FMS_MOD_W  = 4;
  localparam int FMS_DGL_W  = 13;
  localparam int FMS_RST_W  = 9;
  localparam int FMS_CKD_W  = 7;
  localparam int FMS_MON_W  = 19;
  localparam int FMS_WDOG_W = 23;
  localparam logic [FMS_RST_W-1:0] FMS_RST_LIM =
    FMS_RST_W'(FMS_RST_DGL_CYC - 1);
  localparam logic [FMS_CKD_W-1:0] FMS_CKD_LIM =
    FMS_CKD_W'(FMS_CLK_DGL_CYC - 1);
  // fault order: open load, short to supply, severe short to ground,
  // overcurrent, overtemperature, clock fail, undervoltage, overvoltage
  localparam logic [FMS_NFLT-1:0] FMS_FLT_CLK_M = 8'h20;

  typedef enum logic [2:0] {
    FMS_NORMAL = 3'h1,
    FMS_FAIL   = 3'h2,
    FMS_OFF    = 3'h4
  } fms_mode_t;

  typedef struct packed {
    logic                wake_reset_input;
    logic                fail_force_input;
    logic [FMS_NDIR-1:0] direct_drive_inputs;
    logic                clock_pin;
  } fms_pins_t;

  typedef struct packed {
    logic        done;
    logic        toggle_bit;
    logic [15:0] bits;
    logic        qstat1_read;
  } fms_frame_t;

  typedef struct packed {
    fms_pins_t                          s1;
    fms_pins_t                          s2;
    logic [FMS_NDGL-1:0]                dgl;
    logic [FMS_NDGL-1:0][FMS_DGL_W-1:0] dgl_cnt;
    logic                               rst_f;
    logic [FMS_RST_W-1:0]               rst_cnt;
    logic                               clk_f;
    logic [FMS_CKD_W-1:0]               clk_cnt;
    logic                               mon;
    logic                               seen;
    logic [FMS_MON_W-1:0]               mon_cnt;
    logic [FMS_WDOG_W-1:0]              wdog_cnt;
    logic                               tog_last;
    logic                               comm_fail;
    logic                               link_flag;
    fms_mode_t                          mode;
    logic [FMS_NFLT-1:0]                faults;
    logic [FMS_NOUT-1:0]                pout;
    logic                               ext;
    logic                               clk_oe;
  } fms_state_t;

  localparam fms_state_t FMS_STATE_RST = '{mode: FMS_OFF, default: '0};
endpackage

// *** sim/fms_mcu.sv ***
`timescale 1ns/1ps
// controller model: one frame every 100 cycles while its logic supply is up
// kind 1 repeats the toggle, 2 sends 17 bits, 3 reads quick status 1
module fms_mcu
  import fms_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       nrst,
  input  wire logic       logic_ok,
  input  wire logic [1:0] kind,
  input  wire logic       slow,
  output fms_frame_t      frame,
  output logic            clk_out
);
  logic [6:0] cnt_q;
  logic       tog_q;
  logic       tog_n;

  assign tog_n = (kind == 2'h1) ? tog_q : ~tog_q;

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cnt_q <= 7'h00;
      tog_q <= 1'h0;
      frame <= '0;
    end else begin
      cnt_q <= (cnt_q == 7'h63) ? 7'h00 : cnt_q + 7'h01;
      if (cnt_q == 7'h63 && logic_ok) begin
        tog_q             <= tog_n;
        frame.done        <= 1'h1;
        frame.toggle_bit  <= tog_n;
        frame.bits        <= (kind == 2'h2) ? 16'h0011 : 16'h0010;
        frame.qstat1_read <= (kind == 2'h3);
      end else begin
        // idle fields keep moving so a stale value never passes as sent
        frame.done        <= 1'h0;
        frame.toggle_bit  <= ~frame.toggle_bit;
        frame.bits        <= ~frame.bits;
        frame.qstat1_read <= ~frame.qstat1_read;
      end
    end
  end

  // free running pwm clock; the fast setting is beyond the pin filter
  initial begin
    clk_out = 1'h0;
    #7;
    forever #(slow ? 2500 : 100) clk_out = ~clk_out;
  end
endmodule

// *** sim/fms_tb.sv ***
`timescale 1ns/1ps
module testbench
  import fms_pkg::*;
;
  logic       sys_clk, nrst, awake, main_ok, logic_ok, gnd_ok, ext_set;
  logic       sel, slow, ext, pin_o, pin_oe, fail, link, ffl, cvalid;
  logic       rclr, clk_mcu;
  logic [1:0] kind;
  logic [4:0] pwm, ccs, pout;
  logic [7:0] fcond, fflags;
  fms_pins_t  pins, pin_in;
  fms_frame_t frame;
  int         error_cnt, samples_checked;

  // the device drives the shared clock wire while its enable is high
  always_comb begin
    pin_in = pins;
    pin_in.clock_pin = pin_oe ? pin_o : clk_mcu;
  end

  fms_supervisor #(.IN_DGL_CYC(13'h0014), .WDOG_S_CYC(23'h00012c),
    .WDOG_L_CYC(23'h000258), .CLK_LOW_CYC(19'h003e8)) i_dut (
    .SYS_CLK(sys_clk), .NRST(nrst), .PIN_IN(pin_in), .FRAME(frame),
    .WATCHDOG_PERIOD_SELECT(sel), .AWAKE(awake), .MAIN_SUPPLY_OK(main_ok),
    .LOGIC_SUPPLY_OK(logic_ok), .GROUND_OK(gnd_ok), .PWM_CHANNEL(pwm),
    .CHANNEL_CONTROL_SIGNAL(ccs), .EXT_SWITCH_SETTING(ext_set),
    .FAULT_COND(fcond), .POWER_CHANNEL_OUTPUTS(pout),
    .EXTERNAL_SWITCH_CONTROL_OUTPUT(ext), .CLOCK_PIN_O(pin_o),
    .CLOCK_PIN_OE(pin_oe), .FAIL_MODE(fail), .LINK_FAILURE_FLAG(link),
    .FAIL_FORCE_LEVEL(ffl), .CLOCK_VALID(cvalid), .FAULT_FLAGS(fflags),
    .REGS_CLEAR(rclr));

  fms_mcu i_mcu (.clk(sys_clk), .nrst(nrst), .logic_ok(logic_ok),
    .kind(kind), .slow(slow), .frame(frame), .clk_out(clk_mcu));

  initial begin
    sys_clk = 1'h0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  task automatic print_verdict();
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // waits n edges, then lets that edge's updates land before sampling
  task automatic w(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // ends on the edge where the device takes a frame
  task automatic wf();
    int i = 0;
    @(posedge sys_clk);
    while (frame.done !== 1'h1 && i < 300) begin
      @(posedge sys_clk);
      i++;
    end
    if (i == 300) error_cnt++;
  endtask

  // kind is changed only just after a frame, never racing the next one
  task automatic send(input logic [1:0] k);
    wf();
    kind <= k;
    wf();
    kind <= 2'h0;
    w(3);
  endtask

  initial begin
    #1_000_000;
    error_cnt++;
    print_verdict();
  end

  initial begin
    pins = '0;
    {awake, main_ok, logic_ok, gnd_ok, ext_set, slow} = 6'h3f;
    {sel, nrst, kind, fcond} = 12'h000;
    pwm = 5'h12;
    ccs = 5'h0a;
    error_cnt = 0;
    samples_checked = 0;
    w(8);
    chk(rclr, 8'h01);
    chk(pout, 8'h00);
    @(posedge sys_clk);
    nrst <= 1'h1;
    w(6);
    chk(pin_oe, 8'h01);
    chk(pin_o, 8'h01);
    chk(pout, 8'h0a);
    chk(ext, 8'h01);
    @(posedge sys_clk);
    awake <= 1'h0;
    w(4);
    chk(pin_oe, 8'h00);
    chk(ext, 8'h00);
    @(posedge sys_clk);
    awake <= 1'h1;
    pins.wake_reset_input <= 1'h1;
    w(5);
    chk(pin_oe, 8'h00);
    w(300);
    chk(cvalid, 8'h01);
    chk(pout, 8'h12);
    @(posedge sys_clk);
    pins.wake_reset_input <= 1'h0;
    w(380);
    chk(pin_oe, 8'h00);
    w(40);
    chk(pin_oe, 8'h01);
    @(posedge sys_clk);
    pins.wake_reset_input <= 1'h1;
    pins.direct_drive_inputs <= 4'h5;
    w(300);
    chk(pout, 8'h17);
    for (int k = 1; k < 3; k++) begin
      send(k[1:0]);
      chk(link, 8'h01);
      chk(fail, 8'h01);
      chk(pout, 8'h05);
      chk(ext, 8'h00);
      wf();
      w(3);
      chk(fail, 8'h00);
      chk(link, 8'h00);
    end
    for (int k = 0; k < 2; k++) begin
      wf();
      sel <= k[0];
      logic_ok <= 1'h0;
      w(250 + 300 * k);
      chk(fail, 8'h00);
      w(100);
      chk(fail, 8'h01);
      chk(link, 8'h01);
      @(posedge sys_clk);
      logic_ok <= 1'h1;
      wf();
      w(3);
      chk(fail, 8'h00);
    end
    @(posedge sys_clk);
    pins.fail_force_input <= 1'h1;
    w(10);
    chk(ffl, 8'h01);
    @(posedge sys_clk);
    pins.fail_force_input <= 1'h0;
    w(40);
    chk(fail, 8'h00);
    @(posedge sys_clk);
    pins.fail_force_input <= 1'h1;
    w(15);
    chk(fail, 8'h00);
    w(20);
    chk(fail, 8'h01);
    @(posedge sys_clk);
    pins.fail_force_input <= 1'h0;
    w(30);
    wf();
    w(3);
    chk(fail, 8'h00);
    @(posedge sys_clk);
    fcond <= 8'h81;
    slow <= 1'h0;
    w(1300);
    chk(fflags, 8'ha1);
    chk(cvalid, 8'h00);
    send(2'h3);
    chk(fflags, 8'ha1);
    @(posedge sys_clk);
    fcond <= 8'h00;
    slow <= 1'h1;
    w(400);
    chk(fflags, 8'ha1);
    send(2'h3);
    chk(fflags, 8'h00);
    @(posedge sys_clk);
    fcond <= 8'h02;
    w(5);
    @(posedge sys_clk);
    fcond <= 8'h00;
    main_ok <= 1'h0;
    pins.wake_reset_input <= 1'h0;
    w(450);
    chk(pout, 8'h00);
    chk(fflags, 8'h02);
    chk(ext, 8'h01);
    chk(pin_oe, 8'h00);
    @(posedge sys_clk);
    main_ok <= 1'h1;
    gnd_ok <= 1'h0;
    ext_set <= 1'h0;
    w(3);
    chk(pout, 8'h00);
    chk(ext, 8'h01);
    @(posedge sys_clk);
    {gnd_ok, main_ok, logic_ok} <= 3'h4;
    w(3);
    chk(rclr, 8'h01);
    chk(fflags, 8'h00);
    chk(pout, 8'h00);
    print_verdict();
  end
endmodule
